/* hdl/boundary_scan_pkg.sv */
// package: constants, states and carriers of the boundary scan test port
`default_nettype none
package boundary_scan_pkg;

    // ------------------------------------------------------------------
    // register sizes and internal cell position
    // ------------------------------------------------------------------
    localparam int unsigned IR_WIDTH        = 3;
    localparam int unsigned ID_WIDTH        = 32;
    localparam int unsigned CHAIN_LENGTH    = 107;
    localparam int unsigned FLOAT_CELL      = 47;

    // ------------------------------------------------------------------
    // identification field layout
    // ------------------------------------------------------------------
    localparam int unsigned ID_REV_LSB      = 29;
    localparam int unsigned ID_PART_LSB     = 12;
    localparam int unsigned ID_VENDOR_LSB   = 1;
    localparam int unsigned ID_REV_WIDTH    = 3;
    localparam int unsigned ID_PART_WIDTH   = 17;
    localparam int unsigned ID_VENDOR_WIDTH = 11;
    localparam logic        ID_PRESENT_BIT  = 1'h1;

    // ------------------------------------------------------------------
    // instruction codes and capture pattern
    // ------------------------------------------------------------------
    localparam logic [2:0] INSTR_EXTEST     = 3'h0;
    localparam logic [2:0] INSTR_IDCODE     = 3'h1;
    localparam logic [2:0] INSTR_SAMPLE_Z   = 3'h2;
    localparam logic [2:0] INSTR_SAMPLE     = 3'h4;
    localparam logic [2:0] INSTR_BYPASS     = 3'h7;
    localparam logic [2:0] IR_CAPTURE_VALUE = 3'h1;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic BYPASS_CAPTURE_VALUE   = 1'h0;
    localparam logic FLOAT_CELL_PRESET      = 1'h1;

    // ------------------------------------------------------------------
    // test controller states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET = 4'h0,
        RUN_TEST_IDLE    = 4'h1,
        SELECT_DR        = 4'h2,
        CAPTURE_DR       = 4'h3,
        SHIFT_DR         = 4'h4,
        EXIT1_DR         = 4'h5,
        PAUSE_DR         = 4'h6,
        EXIT2_DR         = 4'h7,
        UPDATE_DR        = 4'h8,
        SELECT_IR        = 4'h9,
        CAPTURE_IR       = 4'ha,
        SHIFT_IR         = 4'hb,
        EXIT1_IR         = 4'hc,
        PAUSE_IR         = 4'hd,
        EXIT2_IR         = 4'he,
        UPDATE_IR        = 4'hf
    } tap_state_t;

    // serial inputs from the board test controller, both sampled on rising tck
    typedef struct packed {
        logic tms;
        logic tdi;
    } scan_in_t;

endpackage
`default_nettype wire

/* hdl/boundary_scan_tap.sv */
// boundary scan test access port: controller, instruction and data registers
// Functional notes
// R1: instruction 001 captures the fixed identification word and shifts it out
// R2: instruction 010 captures the pin ring, selects the chain, floats outputs
// R3: instruction 100 captures pins and selects the chain, memory unaffected
// R4: instruction 111 puts the single bypass cell between tdi and tdo
// R5: instruction 000 is external test, capturing the pin ring into the chain
// R6: the tester never loads codes 011, 101 or 110
// R7: identification word is fixed: revision 31:29, part 28:12, vendor 11:1
// R8: identification bit 0 always reads one
// R9: chain is 107 cells, identification 32 bits, bypass one cell
// R10: internal cell 47 gates output drivers in external test, presets high
// R11: tdi sampled on rising tck, tdo changes on falling tck
// R12: power up and controller reset load the identification instruction
// R13: capture-instruction loads 01 into the two lowest instruction bits
// R14: standard sixteen-state controller stepped by tms on rising tck
// R15: a new instruction acts only after update of the instruction register
`default_nettype none
module boundary_scan_tap #(
    parameter logic [2:0]  ID_REVISION = 3'h1,      // arbitrary value
    parameter logic [16:0] ID_PART     = 17'h0abcd, // arbitrary value
    parameter logic [10:0] ID_VENDOR   = 11'h2aa    // arbitrary value
) (
    input  wire logic                      clock,
    input  wire logic                      reset,
    input  wire logic                      tck,
    input  wire boundary_scan_pkg::scan_in_t scan_in,
    input  wire logic [106:0]              pin_ring_in,
    output logic                           tdo,
    output logic                           tdo_enable,
    output logic [106:0]                   pin_ring_drive,
    output logic                           extest_active,
    output logic                           q_drive_enable
);
    import boundary_scan_pkg::*;

    localparam logic [31:0] ID_VALUE = {ID_REVISION, ID_PART, ID_VENDOR, ID_PRESENT_BIT}; // R7 R8

    // ------------------------------------------------------------------
    // crossings into the tck domain
    // ------------------------------------------------------------------
    // reset needs tck edges to reach the controller; a stopped tck holds state
    logic                    rst_meta_reg;
    logic                    reset_tck;
    logic [CHAIN_LENGTH-1:0] pin_meta_reg;
    logic [CHAIN_LENGTH-1:0] pin_sync_reg;
    always_ff @(posedge tck) begin
        rst_meta_reg <= reset;
        reset_tck    <= rst_meta_reg;
        pin_meta_reg <= pin_ring_in;
        pin_sync_reg <= pin_meta_reg;
    end

    // ------------------------------------------------------------------
    // test controller
    // ------------------------------------------------------------------
    tap_state_t state_reg;
    tap_state_t state_next;
    logic       tms;
    logic       tdi;
    assign tms = scan_in.tms;
    assign tdi = scan_in.tdi;
    always_comb begin
        state_next = state_reg; // R14
        unique case (state_reg)
            TEST_LOGIC_RESET: state_next = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
            RUN_TEST_IDLE:    state_next = tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_DR:        state_next = tms ? SELECT_IR : CAPTURE_DR;
            CAPTURE_DR:       state_next = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR:         state_next = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR:         state_next = tms ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR:         state_next = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR:         state_next = tms ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR:        state_next = tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_IR:        state_next = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
            CAPTURE_IR:       state_next = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR:         state_next = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR:         state_next = tms ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR:         state_next = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR:         state_next = tms ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR:        state_next = tms ? SELECT_DR : RUN_TEST_IDLE;
        endcase
    end
    always_ff @(posedge tck) begin
        if (reset_tck) begin
            state_reg <= TEST_LOGIC_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------------
    logic [IR_WIDTH-1:0] ir_shift_reg;
    logic [IR_WIDTH-1:0] ir_shift_next;
    logic [IR_WIDTH-1:0] ir_active_reg;
    logic [IR_WIDTH-1:0] ir_active_next;
    always_comb begin
        ir_shift_next  = ir_shift_reg;
        ir_active_next = ir_active_reg;
        unique case (state_reg)
            TEST_LOGIC_RESET: ir_active_next = INSTR_IDCODE; // R12
            CAPTURE_IR:       ir_shift_next  = IR_CAPTURE_VALUE; // R13
            SHIFT_IR:         ir_shift_next  = {tdi, ir_shift_reg[IR_WIDTH-1:1]}; // R11
            UPDATE_IR:        ir_active_next = ir_shift_reg; // R15
            default:          ir_shift_next  = ir_shift_reg;
        endcase
    end
    always_ff @(posedge tck) begin
        if (reset_tck) begin
            ir_shift_reg  <= IR_CAPTURE_VALUE;
            ir_active_reg <= INSTR_IDCODE; // R12
        end else begin
            ir_shift_reg  <= ir_shift_next;
            ir_active_reg <= ir_active_next;
        end
    end

    // ------------------------------------------------------------------
    // data register selection; unused codes fall back to bypass
    // ------------------------------------------------------------------
    logic sel_id;
    logic sel_chain;
    assign sel_id    = (ir_active_reg == INSTR_IDCODE); // R1
    assign sel_chain = (ir_active_reg == INSTR_EXTEST) || (ir_active_reg == INSTR_SAMPLE_Z)
                    || (ir_active_reg == INSTR_SAMPLE); // R2 R3 R5

    // ------------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------------
    logic                    bypass_reg;
    logic                    bypass_next;
    logic [ID_WIDTH-1:0]     id_shift_reg;
    logic [ID_WIDTH-1:0]     id_shift_next;
    logic [CHAIN_LENGTH-1:0] chain_shift_reg;
    logic [CHAIN_LENGTH-1:0] chain_shift_next;
    logic [CHAIN_LENGTH-1:0] chain_update_reg;
    logic [CHAIN_LENGTH-1:0] chain_update_next;
    logic [CHAIN_LENGTH-1:0] chain_capture;
    // the internal cell has no pin; it captures its own latched value
    always_comb begin
        chain_capture             = pin_sync_reg;
        chain_capture[FLOAT_CELL] = chain_update_reg[FLOAT_CELL]; // R10
    end
    always_comb begin
        bypass_next       = bypass_reg;
        id_shift_next     = id_shift_reg;
        chain_shift_next  = chain_shift_reg;
        chain_update_next = chain_update_reg;
        if (state_reg == TEST_LOGIC_RESET) begin
            chain_update_next[FLOAT_CELL] = FLOAT_CELL_PRESET; // R10
        end
        if (state_reg == CAPTURE_DR) begin
            bypass_next   = BYPASS_CAPTURE_VALUE; // R4
            id_shift_next = ID_VALUE; // R1
            if (sel_chain) begin
                chain_shift_next = chain_capture; // R2 R3 R5
            end
        end
        if (state_reg == SHIFT_DR) begin
            bypass_next   = tdi; // R4
            id_shift_next = {tdi, id_shift_reg[ID_WIDTH-1:1]}; // R1
            if (sel_chain) begin
                chain_shift_next = {tdi, chain_shift_reg[CHAIN_LENGTH-1:1]}; // R9
            end
        end
        if (state_reg == UPDATE_DR && sel_chain) begin
            chain_update_next = chain_shift_reg; // R10
        end
    end

    always_ff @(posedge tck) begin
        if (reset_tck) begin
            bypass_reg                   <= BYPASS_CAPTURE_VALUE;
            id_shift_reg                 <= ID_VALUE;
            chain_shift_reg              <= '0;
            chain_update_reg             <= '0;
            chain_update_reg[FLOAT_CELL] <= FLOAT_CELL_PRESET; // R10
        end else begin
            bypass_reg       <= bypass_next;
            id_shift_reg     <= id_shift_next;
            chain_shift_reg  <= chain_shift_next;
            chain_update_reg <= chain_update_next;
        end
    end

    // ------------------------------------------------------------------
    // serial output, launched on falling tck
    // ------------------------------------------------------------------
    logic tdo_reg;
    logic tdo_next;
    logic tdo_en_reg;
    logic tdo_en_next;
    always_comb begin
        tdo_en_next = (state_reg == SHIFT_IR) || (state_reg == SHIFT_DR);
        if (state_reg == SHIFT_IR) begin
            tdo_next = ir_shift_reg[0];
        end else if (sel_id) begin
            tdo_next = id_shift_reg[0];
        end else if (sel_chain) begin
            tdo_next = chain_shift_reg[0];
        end else begin
            tdo_next = bypass_reg;
        end
    end

    always_ff @(negedge tck) begin
        if (reset_tck) begin
            tdo_reg    <= 1'h0;
            tdo_en_reg <= 1'h0;
        end else begin
            tdo_reg    <= tdo_next; // R11
            tdo_en_reg <= tdo_en_next;
        end
    end

    assign tdo        = tdo_reg;
    assign tdo_enable = tdo_en_reg;

    // ------------------------------------------------------------------
    // output driver control; q_drive_enable crossed into the memory clock domain, extest_active left in tck
    // ------------------------------------------------------------------
    logic q_drive_tck_reg;
    logic q_drive_tck_next;
    logic extest_reg;
    logic extest_next;
    logic q_meta_reg;
    logic q_sync_reg;
    always_comb begin
        extest_next = (ir_active_reg == INSTR_EXTEST); // R5
        if (ir_active_reg == INSTR_EXTEST) begin
            q_drive_tck_next = chain_update_reg[FLOAT_CELL]; // R10
        end else begin
            q_drive_tck_next = (ir_active_reg != INSTR_SAMPLE_Z); // R2
        end
    end

    always_ff @(posedge tck) begin
        if (reset_tck) begin
            q_drive_tck_reg <= 1'h1;
            extest_reg      <= 1'h0;
        end else begin
            q_drive_tck_reg <= q_drive_tck_next;
            extest_reg      <= extest_next;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            q_meta_reg <= 1'h1;
            q_sync_reg <= 1'h1;
        end else begin
            q_meta_reg <= q_drive_tck_reg;
            q_sync_reg <= q_meta_reg;
        end
    end

    assign q_drive_enable = q_sync_reg;
    assign extest_active  = extest_reg;
    assign pin_ring_drive = chain_update_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_ir_capture_pattern: assert property (@(posedge tck) disable iff (reset_tck) // R13
        state_reg == CAPTURE_IR |=> ir_shift_reg[1:0] == 2'h1)
        else $error("capture-ir did not load 01");
    chk_reset_idcode: assert property (@(posedge tck) disable iff (reset_tck) // R12
        state_reg == TEST_LOGIC_RESET |=> ir_active_reg == INSTR_IDCODE)
        else $error("controller reset did not select idcode");
    chk_id_capture_word: assert property (@(posedge tck) disable iff (reset_tck) // R8
        state_reg == CAPTURE_DR |=> id_shift_reg == ID_VALUE && id_shift_reg[0])
        else $error("identification word not captured");
    chk_bypass_capture_low: assert property (@(posedge tck) disable iff (reset_tck) // R4
        state_reg == CAPTURE_DR |=> !bypass_reg)
        else $error("bypass cell not cleared on capture");
    chk_samplez_float: assert property (@(posedge tck) disable iff (reset_tck) // R2
        ir_active_reg == INSTR_SAMPLE_Z |=> !q_drive_tck_reg)
        else $error("outputs not floated in sample z");
    chk_extest_float_cell: assert property (@(posedge tck) disable iff (reset_tck) // R10
        ir_active_reg == INSTR_EXTEST |=> q_drive_tck_reg == $past(chain_update_reg[FLOAT_CELL]))
        else $error("float cell does not steer outputs in extest");
    chk_ir_hold_update: assert property (@(posedge tck) disable iff (reset_tck) // R15
        state_reg != UPDATE_IR && state_reg != TEST_LOGIC_RESET |=> $stable(ir_active_reg))
        else $error("instruction changed outside update");
    chk_tms_reset_five: assert property (@(posedge tck) disable iff (reset_tck) // R14
        tms [*5] |=> state_reg == TEST_LOGIC_RESET)
        else $error("five tms highs did not reach reset");
    chk_chain_shift_in: assert property (@(posedge tck) disable iff (reset_tck) // R9
        state_reg == SHIFT_DR && sel_chain |=> chain_shift_reg[CHAIN_LENGTH-1] == $past(tdi))
        else $error("tdi not shifted into chain head");
    chk_tdo_enable_shift: assert property (@(posedge tck) disable iff (reset_tck) // R11
        state_reg == SHIFT_DR ##1 state_reg == SHIFT_DR |-> tdo_enable)
        else $error("tdo not enabled while shifting");

endmodule
`default_nettype wire

/* tb/scan_master.sv */
// board test controller model: drives tck, tms and tdi, reads tdo
`default_nettype none
module scan_master
    import boundary_scan_pkg::*;
(
    output logic                        tck,
    output boundary_scan_pkg::scan_in_t scan_in,
    input  wire logic                   tdo,
    input  wire logic                   tdo_enable
);
    timeunit 1ns;
    timeprecision 1ps;

    // a released tdo has no pull here; it reads inverted so a late enable shows up
    logic tdo_line;

    assign tdo_line = tdo_enable ? tdo : ~tdo;

    // tck stands low between frames; a step is one full 48 ns period
    initial begin
        tck     = 1'b0;
        scan_in = '0;
    end

    // --------------------------------------------------------------
    // one controller step
    // --------------------------------------------------------------
    // tms and tdi change just after the falling edge and hold through the rise;
    // tdo is read late in the low phase, well after it settled on the fall
    task automatic step(input logic tms, input logic tdi, output logic seen);
        scan_in.tms = tms;
        scan_in.tdi = tdi;
        #24;
        seen = tdo_line;
        tck  = 1'b1;
        #24;
        tck  = 1'b0;
    endtask

    // --------------------------------------------------------------
    // state sequences
    // --------------------------------------------------------------
    task automatic tap_reset();
        logic b;
        repeat (5) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask

    // callers pass only implemented codes; stops in the exit state before update
    task automatic ir_shift(input logic [2:0] code, output logic [2:0] seen);
        logic b;
        step(1'b1, 1'b0, b);
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < 3; i++) step(i == 2, code[i], seen[i]);
    endtask

    task automatic dr_shift(input int len, input logic [106:0] din,
                            output logic [106:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < len; i++) step(i == len - 1, din[i], dout[i]);
    endtask

    // exit1 -> update -> idle, plus one idle step to let the instruction settle
    task automatic finish_scan();
        logic b;
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking testbench of the boundary scan test access port
`default_nettype none
module tb_top
    import boundary_scan_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [2:0]   REV     = 3'h5;      // arbitrary value
    localparam logic [16:0]  PART    = 17'h1b3c5; // arbitrary value
    localparam logic [10:0]  VENDOR  = 11'h0f3;   // arbitrary value
    localparam logic [31:0]  ID_WORD = {REV, PART, VENDOR, ID_PRESENT_BIT};
    localparam logic [106:0] PINS    = 107'h2_f0e1_d2c3_b4a5_9687_7869_5a4b;
    localparam logic [106:0] SIN     = 107'h5_5555_5555_5555_5555_5555_5555;
    localparam logic [106:0] BIT47   = 107'h1 << 47;

    typedef struct {
        logic [2:0]   instr;
        int           len;
        logic [106:0] exp;
        logic [106:0] drv;
        logic         q_pre;
        logic         q;
        logic         ext;
    } row_t;

    logic                        clock;
    logic                        reset;
    logic                        tck;
    boundary_scan_pkg::scan_in_t scan_in;
    logic [106:0]                pin_ring_in;
    logic                        tdo;
    logic                        tdo_enable;
    logic [106:0]                pin_ring_drive;
    logic                        extest_active;
    logic                        q_drive_enable;
    logic                        bit_seen;
    logic [2:0]                  ir_seen;
    logic [106:0]                dout;
    int                          fail_count = 0;
    int                          cmp_count  = 0;
    row_t                        rows [5];

    boundary_scan_tap #(
        .ID_REVISION (REV),
        .ID_PART     (PART),
        .ID_VENDOR   (VENDOR)
    ) boundary_scan_tap_inst (
        .clock          (clock),
        .reset          (reset),
        .tck            (tck),
        .scan_in        (scan_in),
        .pin_ring_in    (pin_ring_in),
        .tdo            (tdo),
        .tdo_enable     (tdo_enable),
        .pin_ring_drive (pin_ring_drive),
        .extest_active  (extest_active),
        .q_drive_enable (q_drive_enable)
    );

    scan_master scan_master_inst (
        .tck        (tck),
        .scan_in    (scan_in),
        .tdo        (tdo),
        .tdo_enable (tdo_enable)
    );

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    initial begin
        reset = 1'h1;
    end

    always @(posedge clock) pin_ring_in <= PINS;

    // --------------------------------------------------------------
    // checking and ending
    // --------------------------------------------------------------
    task automatic check(input logic [106:0] got, input logic [106:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        results();
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        // chain rows run in order: each after the first sees the cell 47 value the previous one latched
        rows[0] = '{INSTR_IDCODE, 32, {75'h0, ID_WORD}, BIT47, 1'h1, 1'h1, 1'h0};
        rows[1] = '{INSTR_BYPASS, 8, {99'h0, SIN[6:0], 1'h0}, BIT47, 1'h1, 1'h1, 1'h0};
        rows[2] = '{INSTR_SAMPLE, 107, PINS | BIT47, SIN, 1'h1, 1'h1, 1'h0};
        rows[3] = '{INSTR_SAMPLE_Z, 107, PINS & ~BIT47, SIN, 1'h1, 1'h0, 1'h0};
        rows[4] = '{INSTR_EXTEST, 107, PINS & ~BIT47, SIN, 1'h0, 1'h0, 1'h1};
        // reset is held long enough for the tck domain to see it with tck running
        repeat (6) scan_master_inst.step(1'h1, 1'h0, bit_seen);
        check(107'(tdo_enable), 107'(1'h0));
        check(107'(q_drive_enable), 107'(1'h1));
        check(107'(extest_active), 107'(1'h0));
        check(pin_ring_drive, BIT47);
        @(posedge clock);
        reset <= 1'h0;
        scan_master_inst.tap_reset();
        foreach (rows[i]) begin
            scan_master_inst.ir_shift(rows[i].instr, ir_seen);
            check(107'(ir_seen), 107'(IR_CAPTURE_VALUE));
            check(107'(q_drive_enable), 107'(rows[i].q_pre));
            scan_master_inst.finish_scan();
            check(107'(q_drive_enable), 107'(rows[i].q));
            check(107'(extest_active), 107'(rows[i].ext));
            scan_master_inst.dr_shift(rows[i].len, SIN, dout);
            check(dout, rows[i].exp);
            scan_master_inst.finish_scan();
            check(pin_ring_drive, rows[i].drv);
        end
        // controller reset in mid external test: cell 47 presets, instruction reverts
        scan_master_inst.tap_reset();
        check(107'(q_drive_enable), 107'(1'h1));
        check(107'(extest_active), 107'(1'h0));
        check(107'(pin_ring_drive[47]), 107'(1'h1));
        scan_master_inst.dr_shift(32, SIN, dout);
        check(dout, {75'h0, ID_WORD});
        scan_master_inst.finish_scan();
        // external test with the preset cell: drivers on, then floated by the update
        scan_master_inst.ir_shift(INSTR_EXTEST, ir_seen);
        check(107'(ir_seen), 107'(IR_CAPTURE_VALUE));
        scan_master_inst.finish_scan();
        check(107'(q_drive_enable), 107'(1'h1));
        check(107'(extest_active), 107'(1'h1));
        scan_master_inst.dr_shift(107, SIN, dout);
        check(dout, PINS | BIT47);
        scan_master_inst.finish_scan();
        check(107'(q_drive_enable), 107'(1'h0));
        check(pin_ring_drive, SIN);
        results();
    end
endmodule
`default_nettype wire
